// [rtl/ssr_regs.svh]
`ifndef SSR_REGS_SVH
`define SSR_REGS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SSR_ADDR_COMMAND 4'h0
`define SSR_ADDR_INT_CONFIG 4'h1
`define SSR_ADDR_RX_CONTROL 4'h3
`define SSR_ADDR_MODE_CONFIG 4'h4
`define SSR_ADDR_SYNC_ONE 4'h6
`define SSR_ADDR_SYNC_TWO 4'h7
`define SSR_ADDR_RX_DATA 4'h8
`define SSR_ADDR_RX_STATUS 4'h9
`define SSR_ADDR_RX_ERROR 4'hA
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SSR_CMD_ERROR_RESET 0
`define SSR_CMD_REARM_FIRST 1
`define SSR_CMD_CRC_RESET 2
`define SSR_CMD_CHANNEL_RESET 3
`define SSR_INT_EXT_ENABLE 0
`define SSR_INT_STATUS_VECTOR 2
`define SSR_INT_MODE_LO 3
`define SSR_RXC_ENABLE 0
`define SSR_RXC_SYNC_INHIBIT 1
`define SSR_RXC_CRC_ENABLE 3
`define SSR_RXC_ENTER_HUNT 4
`define SSR_RXC_AUTO_ENABLE 5
`define SSR_MODE_PARITY_EN 0
`define SSR_MODE_PARITY_EVEN 1
`define SSR_MODE_SYNC_LO 4
`define SSR_ERR_PARITY 4
`define SSR_ERR_OVERRUN 5
`define SSR_ERR_CRC 6
// ----------------------------------------
// Sizes, reset values and timing
// ----------------------------------------
`define SSR_FIFO_DEPTH 2'h3
`define SSR_CHAR_BITS 4'h8
`define SSR_CRC_DELAY_BITS 4'h8
`define SSR_CRC_SHIFT_LAST 4'h7
`define SSR_CRC_POLY 16'hA001
`define SSR_CRC_INIT 16'h0000
`define SSR_REG_RESET 8'h00
`endif

// [rtl/ssr_pkg.sv]
package ssr_pkg;
  // ----------------------------------------
  // Modes
  // ----------------------------------------
  typedef enum logic [1:0] {SSR_INT_NONE, SSR_INT_FIRST, SSR_INT_EVERY, SSR_INT_EVERY_NOPAR}
    ssr_int_mode_t;
  typedef enum logic [1:0] {SSR_SYNC_MONO, SSR_SYNC_BI, SSR_SYNC_RSVD, SSR_SYNC_EXT}
    ssr_sync_mode_t;
  // ----------------------------------------
  // Register bus carrier
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ssr_bus_t;
  // ----------------------------------------
  // Whole receiver state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] rdata;
    logic rxIrq;
    logic specIrq;
    logic extIrq;
    logic clkS1;
    logic clkS2;
    logic clkS3;
    logic datS1;
    logic datS2;
    logic dcdS1;
    logic dcdS2;
    logic dcdS3;
    logic synS1;
    logic synS2;
    logic [7:0] modeCfg;
    logic [7:0] intCfg;
    logic [7:0] rxCtl;
    logic [7:0] syncOne;
    logic [7:0] syncTwo;
    logic hunt;
    logic stripSync;
    logic [15:0] shiftReg;
    logic [3:0] bitCnt;
    logic [2:0][7:0] fifo;
    logic [1:0] cnt;
    logic parErr;
    logic ovrErr;
    logic firstArmed;
    logic [7:0] pendChar;
    logic [3:0] pendCnt;
    logic pendAct;
    logic [7:0] shChar;
    logic [3:0] shCnt;
    logic shAct;
    logic shInc;
    logic [15:0] crc;
    logic crcErr;
  } ssr_state_t;
endpackage : ssr_pkg

// [rtl/ssr_receiver.sv]
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ssr_regs.svh"
module ssr_receiver
  import ssr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire ssr_bus_t bus,
  output logic [7:0] rdata,
  input wire logic rxClockIn,
  input wire logic rxDataIn,
  input wire logic carrierDetectIn_n,
  input wire logic extSyncIn_n,
  output logic rxIrq,
  output logic specialIrq,
  output logic extStatusIrq
);
  // ----------------------------------------
  // State and helpers
  // ----------------------------------------
  ssr_state_t q;
  ssr_state_t d;
  logic bitEdge;
  logic errClr;
  logic carrierOn;

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic b);
    crcStep = (c[0] ^ b) ? ((c >> 1) ^ `SSR_CRC_POLY) : (c >> 1);
  endfunction : crcStep

  function automatic logic cmdBit(input ssr_bus_t b, input int pos);
    cmdBit = b.wr && (b.addr == `SSR_ADDR_COMMAND) && b.wdata[pos];
  endfunction : cmdBit

  assign bitEdge = q.clkS2 & ~q.clkS3;
  assign errClr = cmdBit(bus, `SSR_CMD_ERROR_RESET);
  assign carrierOn = ~q.dcdS2;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [1:0] iMode;
    logic [1:0] sMode;
    logic [3:0] charLen;
    logic [7:0] ch;
    logic pErr;
    logic xfer;
    logic syncHit;
    iMode = 2'h0;
    sMode = 2'h0;
    charLen = 4'h0;
    ch = 8'h00;
    pErr = 1'b0;
    xfer = 1'b0;
    syncHit = 1'b0;
    d = q;
    d.rxIrq = 1'b0;
    d.specIrq = 1'b0;
    d.extIrq = 1'b0;
    d.clkS1 = rxClockIn;
    d.clkS2 = q.clkS1;
    d.clkS3 = q.clkS2;
    d.datS1 = rxDataIn;
    d.datS2 = q.datS1;
    d.dcdS1 = carrierDetectIn_n;
    d.dcdS2 = q.dcdS1;
    d.dcdS3 = q.dcdS2;
    d.synS1 = extSyncIn_n;
    d.synS2 = q.synS1;
    iMode = q.intCfg[`SSR_INT_MODE_LO+:2];
    sMode = q.modeCfg[`SSR_MODE_SYNC_LO+:2];
    charLen = `SSR_CHAR_BITS + {3'h0, q.modeCfg[`SSR_MODE_PARITY_EN]};
    // Register writes
    if (bus.wr)
    begin
      case (bus.addr)
        `SSR_ADDR_INT_CONFIG: d.intCfg = bus.wdata;
        `SSR_ADDR_RX_CONTROL:
        begin
          d.rxCtl = bus.wdata;
          if (bus.wdata[`SSR_RXC_ENTER_HUNT])
          begin
            d.hunt = 1'b1;
          end
        end
        `SSR_ADDR_MODE_CONFIG: d.modeCfg = bus.wdata;
        `SSR_ADDR_SYNC_ONE: d.syncOne = bus.wdata;
        `SSR_ADDR_SYNC_TWO: d.syncTwo = bus.wdata;
        default: d.rxCtl = d.rxCtl;
      endcase
    end
    if (errClr)
    begin
      d.parErr = 1'b0;
      d.ovrErr = 1'b0;
    end
    if (cmdBit(bus, `SSR_CMD_REARM_FIRST))
    begin
      d.firstArmed = 1'b1;
    end
    if (cmdBit(bus, `SSR_CMD_CRC_RESET))
    begin
      d.crc = `SSR_CRC_INIT;
    end
    if (cmdBit(bus, `SSR_CMD_CHANNEL_RESET))
    begin
      d.rxCtl = `SSR_REG_RESET;
      d.hunt = 1'b1;
      d.cnt = 2'h0;
    end
    // Register reads, data one cycle later
    d.rdata = 8'h00;
    if (bus.rd)
    begin
      case (bus.addr)
        `SSR_ADDR_INT_CONFIG: d.rdata = q.intCfg;
        `SSR_ADDR_RX_CONTROL: d.rdata = q.rxCtl;
        `SSR_ADDR_MODE_CONFIG: d.rdata = q.modeCfg;
        `SSR_ADDR_SYNC_ONE: d.rdata = q.syncOne;
        `SSR_ADDR_SYNC_TWO: d.rdata = q.syncTwo;
        `SSR_ADDR_RX_STATUS: d.rdata = {3'h0, q.hunt, carrierOn, 1'b0, q.cnt};
        `SSR_ADDR_RX_ERROR: d.rdata = {1'b0, q.crcErr, q.ovrErr, q.parErr, 4'h0};
        `SSR_ADDR_RX_DATA:
        begin
          if (q.cnt != 2'h0)
          begin
            d.rdata = q.fifo[0];
            d.fifo = {8'h00, q.fifo[2], q.fifo[1]};
            d.cnt = q.cnt - 2'h1;
          end
        end
        default: d.rdata = 8'h00;
      endcase
    end
    // Carrier change interrupt
    if (q.intCfg[`SSR_INT_EXT_ENABLE] && (q.dcdS2 != q.dcdS3))
    begin
      d.extIrq = 1'b1;
    end
    // Serial side, one bit per receive clock rising edge
    if (bitEdge)
    begin
      // CRC delay then shift; result after sixteen bit times
      if (q.shAct)
      begin
        if (q.shInc)
        begin
          d.crc = crcStep(d.crc, q.shChar[q.shCnt[2:0]]);
        end
        d.shCnt = q.shCnt + 4'h1;
        if (q.shCnt == `SSR_CRC_SHIFT_LAST)
        begin
          d.shAct = 1'b0;
          d.crcErr = (d.crc != 16'h0000);
        end
      end
      if (q.pendAct)
      begin
        d.pendCnt = q.pendCnt + 4'h1;
        if (d.pendCnt == `SSR_CRC_DELAY_BITS)
        begin
          d.pendAct = 1'b0;
          d.shAct = 1'b1;
          d.shCnt = 4'h0;
          d.shChar = q.pendChar;
          d.shInc = q.rxCtl[`SSR_RXC_CRC_ENABLE];
        end
      end
      if (q.rxCtl[`SSR_RXC_ENABLE] && (!q.rxCtl[`SSR_RXC_AUTO_ENABLE] || carrierOn))
      begin
        d.shiftReg = {q.datS2, q.shiftReg[15:1]};
        if (q.hunt)
        begin
          case (sMode)
            SSR_SYNC_MONO: syncHit = (d.shiftReg[15:8] == q.syncOne);
            SSR_SYNC_BI: syncHit = (d.shiftReg == {q.syncTwo, q.syncOne});
            SSR_SYNC_EXT: syncHit = ~q.synS2;
            default: syncHit = 1'b0;
          endcase
          if (syncHit)
          begin
            d.hunt = 1'b0;
            d.bitCnt = 4'h0;
            d.stripSync = q.rxCtl[`SSR_RXC_SYNC_INHIBIT];
          end
        end
        else
        begin
          d.bitCnt = q.bitCnt + 4'h1;
          if (d.bitCnt == charLen)
          begin
            d.bitCnt = 4'h0;
            ch = q.modeCfg[`SSR_MODE_PARITY_EN] ? d.shiftReg[14:7] : d.shiftReg[15:8];
            pErr = q.modeCfg[`SSR_MODE_PARITY_EN]
              & ((^d.shiftReg[15:7]) ^ ~q.modeCfg[`SSR_MODE_PARITY_EVEN]);
            if (q.stripSync && (ch == q.syncOne))
            begin
              xfer = 1'b0;
            end
            else
            begin
              d.stripSync = 1'b0;
              xfer = 1'b1;
            end
          end
        end
      end
    end
    // Transfer into the FIFO; set wins over any clear this cycle
    if (xfer)
    begin
      if (d.cnt == `SSR_FIFO_DEPTH)
      begin
        d.fifo[2] = ch;
        d.ovrErr = 1'b1;
      end
      else
      begin
        d.fifo[d.cnt] = ch;
        d.cnt = d.cnt + 2'h1;
      end
      d.parErr = d.parErr | pErr;
      d.pendChar = ch;
      d.pendCnt = 4'h0;
      d.pendAct = 1'b1;
      case (iMode)
        SSR_INT_FIRST:
        begin
          if (d.firstArmed)
          begin
            d.rxIrq = 1'b1;
            d.firstArmed = 1'b0;
          end
          else if (d.ovrErr && (q.cnt == `SSR_FIFO_DEPTH))
          begin
            d.specIrq = 1'b1;
          end
        end
        SSR_INT_EVERY, SSR_INT_EVERY_NOPAR:
        begin
          if (q.intCfg[`SSR_INT_STATUS_VECTOR]
            && ((d.ovrErr && (q.cnt == `SSR_FIFO_DEPTH))
            || (pErr && (iMode == SSR_INT_EVERY))))
          begin
            d.specIrq = 1'b1;
          end
          else
          begin
            d.rxIrq = 1'b1;
          end
        end
        default: d.rxIrq = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
      q.hunt <= 1'b1;
      q.firstArmed <= 1'b1;
      q.clkS1 <= 1'b1;
      q.clkS2 <= 1'b1;
      q.clkS3 <= 1'b1;
      q.dcdS1 <= 1'b1;
      q.dcdS2 <= 1'b1;
      q.dcdS3 <= 1'b1;
      q.synS1 <= 1'b1;
      q.synS2 <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign rxIrq = q.rxIrq;
  assign specialIrq = q.specIrq;
  assign extStatusIrq = q.extIrq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_pend_done;
    q.pendAct && (q.pendCnt == 4'h7) && bitEdge;
  endsequence

  sequence s_shift_start;
    q.shAct && (q.shCnt == 4'h0);
  endsequence

  sequence s_overrun_vectored;
    $rose(q.ovrErr) && q.intCfg[`SSR_INT_STATUS_VECTOR]
      && ((q.intCfg[`SSR_INT_MODE_LO+:2] == SSR_INT_EVERY)
      || (q.intCfg[`SSR_INT_MODE_LO+:2] == SSR_INT_EVERY_NOPAR));
  endsequence

  a_hunt_stays: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.hunt && !bitEdge && !bus.wr |=> q.hunt)
    else $error("hunt left without a bit edge");
  a_fifo_bound: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (q.cnt == `SSR_FIFO_DEPTH) && !bus.rd && !bus.wr |=> q.cnt == `SSR_FIFO_DEPTH)
    else $error("full fifo lost an entry without a read");
  a_overrun_irq: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_overrun_vectored |-> q.specIrq)
    else $error("overrun gave no special interrupt");
  a_first_nopar: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.specIrq && (q.intCfg[`SSR_INT_MODE_LO+:2] == SSR_INT_FIRST) |-> q.ovrErr)
    else $error("special interrupt without overrun in first mode");
  a_ext_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !q.intCfg[`SSR_INT_EXT_ENABLE] |=> !q.extIrq)
    else $error("carrier interrupt while disabled");
  a_overrun_full: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(q.ovrErr) |-> $past(q.cnt) == `SSR_FIFO_DEPTH)
    else $error("overrun without full fifo");
  a_error_sticky: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.parErr && !errClr |=> q.parErr)
    else $error("parity flag lost without reset");
  a_crc_moment: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $changed(q.crcErr) |-> $past(q.shAct) && ($past(q.shCnt) == 4'h7))
    else $error("crc status changed at wrong time");
  a_carrier_irq: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.intCfg[`SSR_INT_EXT_ENABLE] && (q.dcdS2 != q.dcdS3) |=> q.extIrq)
    else $error("carrier change gave no interrupt");
  a_auto_gate: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.rxCtl[`SSR_RXC_AUTO_ENABLE] && !carrierOn |=> $stable(q.shiftReg))
    else $error("data taken without carrier");
  a_none_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.intCfg[`SSR_INT_MODE_LO+:2] == SSR_INT_NONE |=> !q.rxIrq && !q.specIrq)
    else $error("receive interrupt in no-interrupt mode");
  a_first_once: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.rxIrq && (q.intCfg[`SSR_INT_MODE_LO+:2] == SSR_INT_FIRST) |-> !q.firstArmed)
    else $error("first character interrupt left armed");
  a_crc_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_pend_done |=> s_shift_start)
    else $error("crc shift not started after delay");
endmodule : ssr_receiver
`default_nettype wire

// [verification/ssr_tx_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Remote sender, clock stands still between characters
// ----------------------------------------
module ssr_tx_model
(
  output logic rxClockIn,
  output logic rxDataIn
);
  int gapNs = 137;
  initial
  begin
    rxClockIn = 1'b0;
    rxDataIn = 1'b1;
  end
  task automatic send_byte(input logic [8:0] b, input int n);
    #(gapNs);
    for (int i = 0; i < n; i++)
    begin
      rxDataIn = b[i]; // Lowest bit first
      #200 rxClockIn = 1'b1; // One clock per bit
      #400 rxClockIn = 1'b0;
      #200;
    end
    rxDataIn = ~rxDataIn; // No stale level after the frame
  endtask : send_byte
endmodule : ssr_tx_model
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ssr_regs.svh"
module tb_top
  import ssr_pkg::*;
;
  logic clk_sys;
  logic reset_n;
  ssr_bus_t bus;
  logic [7:0] rdata;
  logic rxClockIn;
  logic rxDataIn;
  logic carrierDetectIn_n;
  logic extSyncIn_n;
  logic rxIrq;
  logic specialIrq;
  logic extStatusIrq;
  int miscompares = 0;
  int n_compared = 0;
  int seed = 32'h661B832D;
  logic [7:0] rdQ[$];
  logic [7:0] mskQ[$];
  logic [7:0] sentQ[$];
  logic rdSeen = 1'b0;
  logic [7:0] nRx = 8'h00;
  logic [7:0] nSpec = 8'h00;
  logic [7:0] nExt = 8'h00;
  logic [7:0] rxExp [4] = '{8'h00, 8'h01, 8'h03, 8'h03};
  logic [7:0] spExp [4] = '{8'h00, 8'h01, 8'h01, 8'h01};
  logic [7:0] prExp [4] = '{8'h00, 8'h01, 8'h01, 8'h02};
  logic [7:0] psExp [4] = '{8'h00, 8'h00, 8'h01, 8'h00};
  logic [7:0] base;
  logic [7:0] sBase;
  logic [7:0] bA;
  logic [7:0] bB;
  logic [15:0] crc;

  ssr_receiver i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus), .rdata(rdata),
    .rxClockIn(rxClockIn), .rxDataIn(rxDataIn), .carrierDetectIn_n(carrierDetectIn_n),
    .extSyncIn_n(extSyncIn_n), .rxIrq(rxIrq), .specialIrq(specialIrq),
    .extStatusIrq(extStatusIrq));
  ssr_tx_model i_tx (.rxClockIn(rxClockIn), .rxDataIn(rxDataIn));

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // Checks and verdict
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    miscompares++;
    close_out();
  end
  always @(posedge clk_sys)
  begin
    rdSeen <= bus.rd;
    if (rxIrq === 1'b1)
      nRx <= nRx + 8'h01;
    if (specialIrq === 1'b1)
      nSpec <= nSpec + 8'h01;
    if (extStatusIrq === 1'b1)
      nExt <= nExt + 8'h01;
    if (rdSeen && rdQ.size() > 0)
      chk(rdata & mskQ.pop_front(), rdQ.pop_front());
  end
  // ----------------------------------------
  // Register bus and link helpers
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    rdQ.push_back(e & m);
    mskQ.push_back(m);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
  endtask : rd
  task automatic drain();
    while (sentQ.size() > 0)
      rd(`SSR_ADDR_RX_DATA, sentQ.pop_front(), 8'hFF);
  endtask : drain
  task automatic tx(input logic [7:0] b, input bit keep);
    i_tx.send_byte({1'b0, b}, 8);
    if (keep)
      sentQ.push_back(b);
    repeat (3) @(posedge clk_sys);
  endtask : tx
  task automatic par(input logic [7:0] b, input logic bad);
    i_tx.send_byte({(^b) ^ bad, b}, 9); // Even parity bit follows the data
    sentQ.push_back(b);
    repeat (3) @(posedge clk_sys);
  endtask : par
  function automatic logic [7:0] rnd();
    return 8'($random(seed)) | 8'h80;
  endfunction : rnd
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ `SSR_CRC_POLY) : (r >> 1);
    return r;
  endfunction : crc16
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    bus = '0;
    reset_n = 1'b0;
    carrierDetectIn_n = 1'b0;
    extSyncIn_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    wr(`SSR_ADDR_MODE_CONFIG, 8'h10); // Bisync goes first
    wr(`SSR_ADDR_INT_CONFIG, 8'h15);
    wr(`SSR_ADDR_SYNC_ONE, 8'h16);
    wr(`SSR_ADDR_SYNC_TWO, 8'h32);
    wr(`SSR_ADDR_RX_CONTROL, 8'h13); // Enable last
    rd(`SSR_ADDR_RX_STATUS, 8'h18, 8'h1B);
    tx(8'h00, 1'b0);
    tx(8'h16, 1'b0);
    tx(8'h32, 1'b0);
    chk(nRx, 8'h00);
    tx(8'h16, 1'b0);
    tx(rnd(), 1'b1);
    chk(nRx, 8'h01);
    rd(`SSR_ADDR_RX_STATUS, 8'h09, 8'h1B);
    drain();
    for (int m = 0; m < 4; m++)
    begin
      base = nRx;
      sBase = nSpec;
      wr(`SSR_ADDR_INT_CONFIG, 8'(m << 3) | 8'h05);
      wr(`SSR_ADDR_COMMAND, 8'h02);
      repeat (3) tx(rnd(), 1'b1);
      chk(nRx - base, rxExp[m]);
      bA = rnd();
      tx(bA, 1'b0);
      sentQ[2] = bA;
      chk(nSpec - sBase, spExp[m]);
      drain();
      rd(`SSR_ADDR_RX_ERROR, 8'h20, 8'h30);
      wr(`SSR_ADDR_COMMAND, 8'h01);
      rd(`SSR_ADDR_RX_ERROR, 8'h00, 8'h30);
    end
    @(posedge clk_sys) carrierDetectIn_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk(nExt, 8'h01);
    wr(`SSR_ADDR_RX_CONTROL, 8'h23);
    base = nRx;
    tx(rnd(), 1'b0);
    chk(nRx - base, 8'h00);
    @(posedge clk_sys) carrierDetectIn_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk(nExt, 8'h02);
    tx(rnd(), 1'b1);
    chk(nRx - base, 8'h01);
    drain();
    for (int k = 0; k < 2; k++)
    begin
      i_tx.gapNs = 137 + k * 3000;
      bA = rnd();
      bB = rnd();
      crc = crc16(crc16(16'h0000, bA), bB);
      tx(bA, 1'b1);
      wr(`SSR_ADDR_COMMAND, 8'h04);
      wr(`SSR_ADDR_RX_CONTROL, 8'h0B); // Set before the next transfer
      tx(bB, 1'b1);
      drain();
      tx(crc[7:0], 1'b1);
      tx(crc[15:8] ^ {7'h00, k[0]}, 1'b1);
      drain();
      tx(8'hFF, 1'b1);
      wr(`SSR_ADDR_RX_CONTROL, 8'h03); // Pad excluded
      tx(8'hFF, 1'b1); // Eight more bit clocks
      rd(`SSR_ADDR_RX_ERROR, {1'b0, k[0], 6'h00}, 8'h40);
      drain();
    end
    wr(`SSR_ADDR_COMMAND, 8'h08);
    wr(`SSR_ADDR_MODE_CONFIG, 8'h03); // Monosync, even parity
    wr(`SSR_ADDR_SYNC_ONE, 8'h16);
    wr(`SSR_ADDR_RX_CONTROL, 8'h01);
    tx(8'h16, 1'b0);
    rd(`SSR_ADDR_RX_STATUS, 8'h08, 8'h1B);
    for (int m = 1; m < 4; m++)
    begin
      wr(`SSR_ADDR_INT_CONFIG, 8'(m << 3) | 8'h04);
      wr(`SSR_ADDR_COMMAND, 8'h03);
      rd(`SSR_ADDR_RX_ERROR, 8'h00, 8'h30);
      base = nRx;
      sBase = nSpec;
      par(rnd(), 1'b0);
      par(rnd(), 1'b1);
      chk(nRx - base, prExp[m]);
      chk(nSpec - sBase, psExp[m]);
      drain();
      rd(`SSR_ADDR_RX_ERROR, 8'h10, 8'h30);
    end
    close_out();
  end
endmodule : tb_top
`default_nettype wire
